// ===== core/dcrc_loop_filter.sv
// Purpose: proportional plus integral loop filter
// Assumes: one update pulse per phase measurement
// Notes:   integrator carries four fraction bits
`timescale 1ns/100ps
`include "dcrc_regs.svh"

module dcrc_loop_filter #(
  parameter int CORR_W = 32
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // control
  input  wire logic [2:0]               pgain_code,
  input  wire logic [3:0]               igain_code,
  input  wire logic                     update,
  input  wire logic                     clear,
  input  wire dcrc_pkg::dcrc_phase_t    phase_err,
  // result
  output logic signed [CORR_W-1:0]      correction
);

  logic signed [CORR_W-1:0] acc_r;
  logic signed [CORR_W-1:0] err_ext;
  logic signed [CORR_W-1:0] prop;
  logic [3:0]               ishift;

  assign err_ext = CORR_W'(phase_err);

  // codes 1010 and above all behave as the top coefficient
  assign ishift = (igain_code > `DCRC_IGAIN_CLAMP) ?
                  `DCRC_IGAIN_CLAMP : igain_code;

  // gain doubles per code step from the base exponent
  // four-bit sum: code 7 plus base 5 would wrap in three bits
  assign prop = err_ext <<< (4'(pgain_code) + 4'(`DCRC_PGAIN_BASE));

  // ***************************************************************
  // integrator
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= '0;
    end else if (clear) begin
      acc_r <= '0;
    end else if (update) begin
      acc_r <= acc_r + (err_ext <<< ishift);
    end
  end

  assign correction = prop + (acc_r >>> `DCRC_IGAIN_FRAC);

  a_integ_step: assert property (@(posedge clk) disable iff (!rst_b)
    update && !clear |=>
      acc_r == $past(acc_r) + ($past(err_ext) <<< $past(ishift)))
    else $error("integrator step wrong");

  a_prop_gain: assert property (@(posedge clk) disable iff (!rst_b)
    correction - (acc_r >>> `DCRC_IGAIN_FRAC)
    == err_ext * (1 << (`DCRC_PGAIN_BASE + int'(pgain_code))))
    else $error("proportional gain wrong");

endmodule

// ===== core/dcrc_nco.sv
// Purpose: numerically controlled oscillator for the recovered clock
// Assumes: core clock stands in for the high-frequency reference
// Notes:   half period is integer part plus fractional carry
`timescale 1ns/100ps
`include "dcrc_regs.svh"

module dcrc_nco #(
  parameter int CORR_W     = 32,
  parameter int CORR_SHIFT = 8
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // frequency setting
  input  wire logic [7:0]               int_word,
  input  wire logic [15:0]              resid,
  input  wire logic                     closed_loop,
  input  wire logic signed [CORR_W-1:0] correction,
  // output
  output logic                          rec_clk
);

  logic [24:0]              period;
  logic signed [CORR_W+1:0] adj;
  logic [24:0]              eff;
  logic [15:0]              frac_r;
  logic [8:0]               cnt_r;
  logic [16:0]              frac_sum;
  logic                     half_done;

  // integer part is stored as base minus integer
  assign period = {`DCRC_FACTOR_BASE - {1'b0, int_word}, resid};

  // a shrinking period speeds the clock; clamp keeps one cycle min
  always_comb begin
    adj = (CORR_W+2)'(signed'({1'b0, period}));
    if (closed_loop) begin
      adj = adj - (CORR_W+2)'(correction >>> CORR_SHIFT);
    end
    if (adj < (CORR_W+2)'(32'sh10000)) begin
      eff = 25'h10000;
    end else if (adj > (CORR_W+2)'(32'sh1ff0000)) begin
      // no fraction at the top, so a carry cannot wrap the counter
      eff = 25'h1ff0000;
    end else begin
      eff = adj[24:0];
    end
  end

  assign frac_sum  = {1'b0, frac_r} + {1'b0, eff[15:0]};
  assign half_done = (cnt_r <= 9'h001);

  // ***************************************************************
  // half period counter
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= 9'h001;
      frac_r  <= '0;
      rec_clk <= 1'b0;
    end else if (half_done) begin
      frac_r  <= frac_sum[15:0];
      cnt_r   <= eff[24:16] + {8'h00, frac_sum[16]};
      rec_clk <= ~rec_clk;
    end else begin
      cnt_r <= cnt_r - 9'h001;
    end
  end

  a_toggle_on_done: assert property (@(posedge clk)
    disable iff (!rst_b) half_done |=> rec_clk != $past(rec_clk))
    else $error("recovered clock missed a toggle");

endmodule

// ===== core/dcrc_pkg.sv
// Purpose: shared types of the clock recovery loop block
// Assumes: nothing
// Notes:   constants live in dcrc_regs.svh
package dcrc_pkg;

  // phase detector states
  typedef enum logic [0:0] {
    PD_ACQUIRE,
    PD_TRACK
  } dcrc_pd_state_e;

  typedef logic signed [10:0] dcrc_phase_t;

endpackage

// ===== core/dcrc_regs.svh
// Purpose: register offsets, field positions and reset values of the
//          receive clock recovery loop configuration block
// Assumes: 8-bit host write port, byte addresses as printed
// Notes:   definitions only
`ifndef DCRC_REGS_SVH
`define DCRC_REGS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define DCRC_ADDR_RESID_LO   8'hd5
`define DCRC_ADDR_RESID_HI   8'hd6
`define DCRC_ADDR_INT_WORD   8'hd7
`define DCRC_ADDR_GAINS      8'hd8
`define DCRC_ADDR_PHASE_INIT 8'hdb
`define DCRC_ADDR_RX_RESET   8'hf1
`define DCRC_ADDR_PD_RESTART 8'hf6

// ***************************************************************
// fields and reset values
// ***************************************************************
`define DCRC_PGAIN_MSB       6
`define DCRC_PGAIN_LSB       4
`define DCRC_IGAIN_MSB       3
`define DCRC_IGAIN_LSB       0
`define DCRC_RESID_RST       16'h0000
`define DCRC_INT_WORD_RST    8'h00
`define DCRC_GAINS_RST       8'h00
`define DCRC_PHASE_INIT_RST  8'h80

// ***************************************************************
// loop constants
// ***************************************************************
`define DCRC_FACTOR_BASE     9'h101
`define DCRC_WIN_LAST        10'h3ff
`define DCRC_WIN_CENTER      10'h200
`define DCRC_PGAIN_BASE      5
`define DCRC_IGAIN_FRAC      4
`define DCRC_IGAIN_CLAMP     4'ha

`endif

// ===== core/dcrc_top.sv
// Purpose: receive clock recovery loop configuration and control
// Assumes: host write strobe and all inputs synchronous to CORE_CLK
// Notes:   write-only registers; loop state shown on status outputs
`timescale 1ns/100ps
`include "dcrc_regs.svh"

// Notes on behaviour
// - 16-bit residual with integer word sets open or starting frequency.
// - residual enters loop only on receive reset write or in-sync entry.
// - proportional codes 0..7 select gains 2^5 to 2^12.
// - integral codes 0..9 select 2^-4 to 2^5; 10..15 give 2^6.
// - gain settings cover loop bandwidths 0.2 Hz to 3 Hz.
// - initial point comes from host register or automatic alignment.
// - with host init, detector returns to that point on loop error.
// - comparison window spans 1024 phase-sample cycles.
// - host initial point is multiplied by four before use.
// - restart write clears phase error, reloads window, clears pending errors unless a loop error coincides.
// - detector advances on the general-purpose phase sample clock.
// - loop synthesizes clock from a free-running high-frequency reference.
module dcrc_top #(
  parameter int CORR_W     = 32,
  parameter int CORR_SHIFT = 8
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  // host write port
  input  wire logic [7:0]  HOST_ADDR,
  input  wire logic [7:0]  HOST_WDATA,
  input  wire logic        HOST_WR,
  // loop controls
  input  wire logic        OPEN_LOOP_SELECT,
  input  wire logic        PHASE_INIT_SELECT,
  input  wire logic        FAST_ACQUIRE_ENABLE,
  // timing inputs
  input  wire logic        PHASE_SAMPLE_TICK,
  input  wire logic        REF_FRAME_PULSE,
  input  wire logic        MASTER_IN_SYNC,
  // status and clock out
  output logic [10:0]      PHASE_ERROR,
  output logic             LOOP_ERR_PEND,
  output logic [15:0]      ACTIVE_RESID,
  output logic             RECOVERED_CLK
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  // ***************************************************************
  // host registers
  // ***************************************************************
  logic [15:0] resid_r;
  logic [7:0]  int_word_r;
  logic [7:0]  gains_r;
  logic [7:0]  phase_init_r;
  logic        wr_resid_lo;
  logic        wr_resid_hi;
  logic        wr_int;
  logic        wr_gains;
  logic        wr_init;
  logic        wr_rx_reset;
  logic        wr_restart;

  always_comb begin
    wr_resid_lo = 1'b0;
    wr_resid_hi = 1'b0;
    wr_int      = 1'b0;
    wr_gains    = 1'b0;
    wr_init     = 1'b0;
    wr_rx_reset = 1'b0;
    wr_restart  = 1'b0;
    if (!HOST_WR) begin
      wr_int = 1'b0;
    end else if (HOST_ADDR == `DCRC_ADDR_RESID_LO) begin
      wr_resid_lo = 1'b1;
    end else if (HOST_ADDR == `DCRC_ADDR_RESID_HI) begin
      wr_resid_hi = 1'b1;
    end else if (HOST_ADDR == `DCRC_ADDR_INT_WORD) begin
      wr_int = 1'b1;
    end else if (HOST_ADDR == `DCRC_ADDR_GAINS) begin
      wr_gains = 1'b1;
    end else if (HOST_ADDR == `DCRC_ADDR_PHASE_INIT) begin
      wr_init = 1'b1;
    end else if (HOST_ADDR == `DCRC_ADDR_RX_RESET) begin
      wr_rx_reset = 1'b1;
    end else if (HOST_ADDR == `DCRC_ADDR_PD_RESTART) begin
      wr_restart = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      resid_r      <= `DCRC_RESID_RST;
      int_word_r   <= `DCRC_INT_WORD_RST;
      gains_r      <= `DCRC_GAINS_RST;
      phase_init_r <= `DCRC_PHASE_INIT_RST;
    end else begin
      if (wr_resid_lo) begin
        resid_r[7:0] <= HOST_WDATA;
      end
      if (wr_resid_hi) begin
        resid_r[15:8] <= HOST_WDATA;
      end
      if (wr_int) begin
        int_word_r <= HOST_WDATA;
      end
      if (wr_gains) begin
        gains_r <= {1'b0, HOST_WDATA[6:0]};
      end
      if (wr_init) begin
        phase_init_r <= HOST_WDATA;
      end
    end
  end

  // ***************************************************************
  // residual hand-over into the loop
  // ***************************************************************
  // the written residual is held back so a half-written pair of bytes
  // never reaches the oscillator
  logic sync_d_r;
  logic sync_rise;
  logic resid_load;

  assign sync_rise  = MASTER_IN_SYNC && !sync_d_r;
  assign resid_load = wr_rx_reset || sync_rise;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_d_r <= 1'b0;
    end else begin
      sync_d_r <= MASTER_IN_SYNC;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ACTIVE_RESID <= `DCRC_RESID_RST;
    end else if (resid_load) begin
      ACTIVE_RESID <= resid_r;
    end
  end

  // ***************************************************************
  // phase detector
  // ***************************************************************
  dcrc_pkg::dcrc_pd_state_e state_r;
  logic [9:0]               win_cnt_r;
  logic                     miss_r;
  logic                     at_end;
  logic                     loop_err;
  logic                     meas;
  logic [9:0]               host_point;
  dcrc_pkg::dcrc_phase_t    err_now;

  assign at_end     = PHASE_SAMPLE_TICK && (win_cnt_r == `DCRC_WIN_LAST);
  // a whole window without a reference event is a loop error
  assign loop_err   = at_end && miss_r && !REF_FRAME_PULSE;
  assign host_point = {phase_init_r, 2'b00};
  assign meas       = REF_FRAME_PULSE && (state_r == dcrc_pkg::PD_TRACK)
                      && !wr_restart;
  assign err_now    = dcrc_pkg::dcrc_phase_t'({1'b0, win_cnt_r})
                      - dcrc_pkg::dcrc_phase_t'({1'b0, `DCRC_WIN_CENTER});

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r   <= dcrc_pkg::PD_ACQUIRE;
      win_cnt_r <= `DCRC_WIN_CENTER;
    end else if (wr_restart || loop_err) begin
      if (PHASE_INIT_SELECT) begin
        state_r   <= dcrc_pkg::PD_TRACK;
        win_cnt_r <= host_point;
      end else begin
        state_r   <= dcrc_pkg::PD_ACQUIRE;
        win_cnt_r <= `DCRC_WIN_CENTER;
      end
    end else begin
      case (state_r)
        dcrc_pkg::PD_ACQUIRE: begin
          // automatic init puts the first reference event at centre
          if (REF_FRAME_PULSE) begin
            state_r   <= dcrc_pkg::PD_TRACK;
            win_cnt_r <= `DCRC_WIN_CENTER;
          end else if (PHASE_SAMPLE_TICK) begin
            win_cnt_r <= win_cnt_r + 10'h001;
          end
        end
        default: begin
          if (PHASE_SAMPLE_TICK) begin
            win_cnt_r <= win_cnt_r + 10'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      miss_r <= 1'b0;
    end else if (wr_restart || REF_FRAME_PULSE || loop_err) begin
      miss_r <= 1'b0;
    end else if (at_end) begin
      miss_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PHASE_ERROR <= '0;
    end else if (wr_restart) begin
      PHASE_ERROR <= '0;
    end else if (meas) begin
      PHASE_ERROR <= err_now;
    end
  end

  // a loop error in the restart cycle is kept: set beats clear
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LOOP_ERR_PEND <= 1'b0;
    end else if (loop_err) begin
      LOOP_ERR_PEND <= 1'b1;
    end else if (wr_restart) begin
      LOOP_ERR_PEND <= 1'b0;
    end
  end

  // ***************************************************************
  // loop filter and oscillator
  // ***************************************************************
  logic signed [CORR_W-1:0] correction;
  logic                     filt_clear;

  // fast acquisition forgets the learnt frequency on each restart
  assign filt_clear = resid_load || OPEN_LOOP_SELECT
                      || (FAST_ACQUIRE_ENABLE && wr_restart);

  dcrc_loop_filter #(.CORR_W(CORR_W)) u_filter (
    .clk        (CORE_CLK),
    .rst_b      (RST_B),
    .pgain_code (gains_r[`DCRC_PGAIN_MSB:`DCRC_PGAIN_LSB]),
    .igain_code (gains_r[`DCRC_IGAIN_MSB:`DCRC_IGAIN_LSB]),
    .update     (meas),
    .clear      (filt_clear),
    .phase_err  (err_now),
    .correction (correction)
  );

  // reference runs free of the line clocks; correction trims the oscillator half period
  dcrc_nco #(.CORR_W(CORR_W), .CORR_SHIFT(CORR_SHIFT)) u_nco (
    .clk         (CORE_CLK),
    .rst_b       (RST_B),
    .int_word    (int_word_r),
    .resid       (ACTIVE_RESID),
    .closed_loop (!OPEN_LOOP_SELECT),
    .correction  (correction),
    .rec_clk     (RECOVERED_CLK)
  );

  // ***************************************************************
  // checks
  // ***************************************************************

  a_restart_clr_err: assert property (
    wr_restart |=> PHASE_ERROR == 11'h000)
    else $error("restart left phase error");
  a_restart_clr_pend: assert property (
    wr_restart && !loop_err |=> !LOOP_ERR_PEND)
    else $error("restart left pending error");
  a_host_init_point: assert property (
    (wr_restart || loop_err) && PHASE_INIT_SELECT
    |=> win_cnt_r == {$past(phase_init_r), 2'b00})
    else $error("host init point not used");
  a_resid_load_val: assert property (
    resid_load |=> ACTIVE_RESID == $past(resid_r))
    else $error("residual not loaded");
  a_resid_hold_val: assert property (
    !resid_load |=> $stable(ACTIVE_RESID))
    else $error("residual changed without load");
  a_err_sets_pend: assert property (
    loop_err |=> LOOP_ERR_PEND ##1 LOOP_ERR_PEND || $past(wr_restart))
    else $error("loop error not pending");
  a_window_wrap: assert property (
    at_end && !REF_FRAME_PULSE && !wr_restart && !loop_err
    && state_r == dcrc_pkg::PD_TRACK |=> win_cnt_r == 10'h000)
    else $error("window did not wrap");
  a_auto_center: assert property (
    state_r == dcrc_pkg::PD_ACQUIRE && REF_FRAME_PULSE && !wr_restart
    && !loop_err |=> win_cnt_r == `DCRC_WIN_CENTER)
    else $error("auto init not at centre");
  a_meas_phase: assert property (
    meas |=> PHASE_ERROR == $past(err_now))
    else $error("phase error not captured");

  c_restart: cover property (wr_restart ##[1:20] meas);
  c_loop_err: cover property (loop_err);
  c_sync_load: cover property (sync_rise);

endmodule

// ===== dv/dcrc_framer_model.sv
// Purpose: framer side model timing the recovered receive clock
// Assumes: core clock is the time base of every measurement
// Notes:   reports the length of the last half period in core cycles
`timescale 1ns/100ps

// ***************************************************************
// recovered clock timing
// ***************************************************************
module dcrc_framer_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // recovered clock in
  input  wire logic        rec_clk,
  // measurement
  output logic [9:0]       half_len,
  output logic [15:0]      n_edges
);
  logic       prev_r;
  logic [9:0] cnt_r;

  // framer takes the clock as it comes, no phase relation assumed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r   <= 1'b0;
      cnt_r    <= 10'h001;
      half_len <= 10'h000;
      n_edges  <= 16'h0000;
    end else begin
      prev_r <= rec_clk;
      // each toggle closes one half period
      if (rec_clk != prev_r) begin
        half_len <= cnt_r;
        cnt_r    <= 10'h001;
        n_edges  <= n_edges + 16'h0001;
      end else begin
        cnt_r <= cnt_r + 10'h001;
      end
    end
  end
endmodule

// ===== dv/test_dpll_clock_recovery_config.sv
// Purpose: self-checking bench of the clock recovery loop block
// Assumes: inputs change on the falling edge of the core clock
// Notes:   fixed seed, so every run repeats
`timescale 1ns/100ps

// ***************************************************************
// bench top
// ***************************************************************
module test_dpll_clock_recovery_config;
  logic        core_clk;
  logic        rst_b;
  logic [7:0]  host_addr;
  logic [7:0]  host_wdata;
  logic        host_wr;
  logic        open_loop;
  logic        init_sel;
  logic        fast_acquire_enable;
  logic        tick;
  logic        ev;
  logic        in_sync;
  logic [10:0] phase_error;
  logic        err_pend;
  logic [15:0] active_resid;
  logic        rec_clk;
  logic [9:0]  half_len;
  logic [15:0] n_edges;
  int          n_errors;
  int          num_checks;
  int          seed;
  logic [15:0] d;
  logic [10:0] e;
  logic [9:0]  h;
  logic [9:0]  h2;
  logic [7:0]  p;
  logic [7:0]  w;
  int          n;
  int          i;

  dcrc_top i_dcrc_top (
    .CORE_CLK            (core_clk),
    .RST_B               (rst_b),
    .HOST_ADDR           (host_addr),
    .HOST_WDATA          (host_wdata),
    .HOST_WR             (host_wr),
    .OPEN_LOOP_SELECT    (open_loop),
    .PHASE_INIT_SELECT   (init_sel),
    .FAST_ACQUIRE_ENABLE (fast_acquire_enable),
    .PHASE_SAMPLE_TICK   (tick),
    .REF_FRAME_PULSE     (ev),
    .MASTER_IN_SYNC      (in_sync),
    .PHASE_ERROR         (phase_error),
    .LOOP_ERR_PEND       (err_pend),
    .ACTIVE_RESID        (active_resid),
    .RECOVERED_CLK       (rec_clk)
  );

  dcrc_framer_model i_dcrc_framer_model (
    .clk      (core_clk),
    .rst_b    (rst_b),
    .rec_clk  (rec_clk),
    .half_len (half_len),
    .n_edges  (n_edges)
  );

  always #12.5 core_clk = ~core_clk;

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    host_addr  = a;
    host_wdata = v;
    host_wr    = 1'b1;
    @(negedge core_clk);
    host_wr = 1'b0;
  endtask

  task automatic restart;
    wr(8'hf6, 8'($random(seed)));
    chk({5'h00, phase_error}, 16'h0000);
    chk({15'h0000, err_pend}, 16'h0000);
  endtask

  task automatic ticks(input int k);
    if (k > 0) begin
      @(negedge core_clk);
      tick = 1'b1;
      repeat (k) @(negedge core_clk);
      tick = 1'b0;
    end
  endtask

  task automatic frame_event;
    @(negedge core_clk);
    ev = 1'b1;
    @(negedge core_clk);
    ev = 1'b0;
    @(negedge core_clk);
  endtask

  // first half period after a change may be partial, so two are dropped
  task automatic measure(output logic [9:0] len);
    logic [15:0] e0;
    int          j;
    repeat (3) begin
      e0 = n_edges;
      j  = 0;
      while (n_edges === e0 && j < 1200) begin
        @(negedge core_clk);
        j++;
      end
      if (j >= 1200) begin
        n_errors++;
        conclude;
      end
    end
    len = half_len;
  endtask

  function automatic logic [10:0] exp_err(input logic [7:0] pt, input int k);
    return 11'((int'(pt) * 4 + k) % 1024 - 512);
  endfunction

  initial begin
    core_clk   = 1'b0;
    rst_b      = 1'b0;
    host_addr  = 8'h00;
    host_wdata = 8'h00;
    host_wr    = 1'b0;
    open_loop  = 1'b1;
    init_sel   = 1'b1;
    fast_acquire_enable   = 1'b0;
    tick       = 1'b0;
    ev         = 1'b0;
    in_sync    = 1'b0;
    n_errors   = 0;
    num_checks = 0;
    seed       = 32'h7da0e960;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    chk(active_resid, 16'h0000);
    chk({15'h0000, err_pend}, 16'h0000);
    // residual held back until a load trigger, unmapped write ignored
    d = 16'($random(seed));
    wr(8'hd5, d[7:0]);
    wr(8'hd6, d[15:8]);
    wr(8'hd9, 8'h5a);
    chk(active_resid, 16'h0000);
    wr(8'hf1, 8'h00);
    @(negedge core_clk);
    chk(active_resid, d);
    d = 16'($random(seed));
    wr(8'hd5, d[7:0]);
    wr(8'hd6, d[15:8]);
    @(negedge core_clk);
    in_sync = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(active_resid, d);
    in_sync = 1'b0;
    // open loop: integer word alone, then half fraction adds one cycle
    for (i = 0; i < 3; i++) begin
      w = (i == 0) ? 8'hff : 8'hf0 | 8'($random(seed) & 15);
      wr(8'hd7, w);
      wr(8'hd5, 8'h00);
      wr(8'hd6, 8'h00);
      wr(8'hf1, 8'h00);
      measure(h);
      chk({6'h00, h}, 16'(257 - int'(w)));
      wr(8'hd6, 8'h80);
      wr(8'hf1, 8'h00);
      measure(h);
      measure(h2);
      chk(16'(h + h2), 16'(515 - 2 * int'(w)));
    end
    // host initial point, window position at frame event
    for (i = 0; i < 6; i++) begin
      p = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : (i == 2) ? 8'hff
        : 8'($random(seed));
      n = (i < 3) ? i * 511 : $random(seed) & 32'h3ff;
      wr(8'hdb, p);
      restart;
      ticks(n);
      frame_event;
      chk({5'h00, phase_error}, {5'h00, exp_err(p, n)});
      chk({15'h0000, err_pend}, 16'h0000);
    end
    // full window without event: error set, detector back at init point
    p = 8'($random(seed));
    wr(8'hdb, p);
    restart;
    @(negedge core_clk);
    tick = 1'b1;
    i = 0;
    while (err_pend !== 1'b1 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    tick = 1'b0;
    if (i >= 3000) begin
      n_errors++;
      conclude;
    end
    chk({15'h0000, err_pend}, 16'h0001);
    frame_event;
    e = exp_err(p, 0);
    chk({5'h00, phase_error}, {5'h00, e});
    restart;
    // automatic init aligns the first event to the window centre
    init_sel = 1'b0;
    restart;
    frame_event;
    n = $random(seed) & 32'hff;
    ticks(n);
    frame_event;
    chk({5'h00, phase_error}, {5'h00, exp_err(8'h80, n)});
    // closed loop at zero phase error keeps the nominal half period
    open_loop = 1'b0;
    init_sel  = 1'b1;
    fast_acquire_enable  = 1'b1;
    w = 8'hf8;
    wr(8'hd7, w);
    wr(8'hdb, 8'h80);
    // whole cycles only: a leftover half fraction would alternate lengths
    wr(8'hd6, 8'h00);
    wr(8'hf1, 8'h00);
    for (i = 0; i < 16; i++) begin
      wr(8'hd8, {1'b0, 3'(i), 4'(i)});
      restart;
      frame_event;
      chk({5'h00, phase_error}, 16'h0000);
      measure(h);
      chk({6'h00, h}, 16'(257 - int'(w)));
      // nonzero phase error under this gain code exercises the gain check
      ticks($random(seed) & 32'hff);
    end
    conclude;
  end
endmodule
